// ---- ddtdc_pkg.sv ----
package ddtdc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_NS = 800;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Delay line and lock window
	localparam logic [8:0] TAP_MAX = 9'h1B0;
	localparam logic [4:0] LOCK_DROP_STEPS = 5'h04;
	localparam logic [4:0] LOCK_GAIN_STEPS = 5'h03;
	localparam int GUARD_SHIFT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [6:0] ADR_OUT_DRV = 7'h01;
	localparam logic [6:0] ADR_IRQ_EN = 7'h03;
	localparam logic [6:0] ADR_IRQ_FLG = 7'h04;
	localparam logic [6:0] ADR_PD = 7'h24;
	localparam logic [6:0] ADR_DUTY = 7'h25;
	localparam logic [6:0] ADR_GAIN = 7'h26;
	localparam logic [6:0] ADR_PHASE = 7'h27;
	localparam logic [6:0] ADR_TAP = 7'h28;
	localparam logic [6:0] ADR_GUARD = 7'h29;
	localparam logic [6:0] ADR_STAT = 7'h2A;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int DCO_PD_BIT = 5;
	localparam int IRQ_LCK_BIT = 2;
	localparam int IRQ_LST_BIT = 3;
	localparam int SLOPE_POS_BIT = 6;
	localparam int RUN_BIT = 0;
	localparam int GAIN_LSB = 1;
	localparam int READBACK_BIT = 3;
	localparam int SEARCH_EN_BIT = 6;
	localparam int TAP_LSB_BIT = 7;
	localparam int RELOCK_RESTART_BIT = 5;
	localparam int RETRY_BIT = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_TAP_REG = 8'h6C;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} ddtdc_wr_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SEARCH = 5'b00010,
		ST_SLOPE = 5'b00100,
		ST_TRACK = 5'b01000,
		ST_FAILED = 5'b10000
	} ddtdc_state_e;

	typedef enum logic [2:0] {
		SM_ALT = 3'b001,
		SM_UP = 3'b010,
		SM_DN = 3'b100
	} ddtdc_smode_e;

endpackage

// ---- ddtdc_phase_sync.sv ----
`timescale 1ns/10ps
module ddtdc_phase_sync import ddtdc_pkg::*; #(
	parameter int WIDTH = 5,
	parameter int SETTLE = SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Analog phase detector
	input wire logic [WIDTH-1:0] phase_async,
	// Controller side
	input wire logic retune,
	output logic [WIDTH-1:0] phase,
	output logic sample
);

	localparam int CW = $clog2(SETTLE + 1);
	localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

	logic [WIDTH-1:0] meta_ff;
	logic [CW-1:0] cnt_ff;
	logic ready_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Bus is only used after the settle time, so bit skew in the pair is harmless
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			phase <= '0;
		end else begin
			meta_ff <= phase_async;
			phase <= meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Each new tap restarts the settle wait before the detector is trusted
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= '0;
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= (cnt_ff == LAST) && !retune; // R03
			if (retune || cnt_ff == LAST) begin
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + CW'(1);
			end
		end
	end

	// A tap written from the bus lands out of step with the count; its stale sample is dropped
	assign sample = ready_ff && !retune; // R03

	a_settle_wait: assert property (@(posedge clk) disable iff (!rst_b) // R03
		retune |=> !sample [*8]) else $error("phase sampled before settle time");

endmodule // ddtdc_phase_sync

// ---- ddtdc_spi_slave.sv ----
`timescale 1ns/10ps
module ddtdc_spi_slave import ddtdc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial pins
	input wire logic sclk_pin,
	input wire logic cs_b_pin,
	input wire logic sdio_in_pin,
	output logic sdio_out,
	output logic sdio_oe,
	// Register side
	output ddtdc_wr_s wr,
	output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data
);

	logic [2:0] sclk_ff;
	logic [1:0] cs_b_ff;
	logic [1:0] sdi_ff;
	logic [4:0] cnt_ff;
	logic [6:0] sh_ff;
	logic [7:0] tx_ff;
	logic rd_ff;
	logic rise;
	logic fall;
	logic active;

	assign rise = sclk_ff[1] & ~sclk_ff[2];
	assign fall = ~sclk_ff[1] & sclk_ff[2];
	assign active = ~cs_b_ff[1];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_ff <= 3'h0;
			cs_b_ff <= 2'h3;
			sdi_ff <= 2'h0;
		end else begin
			sclk_ff <= {sclk_ff[1:0], sclk_pin};
			cs_b_ff <= {cs_b_ff[0], cs_b_pin};
			sdi_ff <= {sdi_ff[0], sdio_in_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame: read flag, 7-bit address, 8 data bits, MSB first, sampled on rising sclk
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 5'h00;
			sh_ff <= 7'h00;
			rd_ff <= 1'b0;
			rd_addr <= 7'h00;
			wr <= '0;
		end else begin
			wr.wr <= 1'b0;
			if (!active) begin
				cnt_ff <= 5'h00;
			end else if (rise && cnt_ff != 5'h10) begin
				sh_ff <= {sh_ff[5:0], sdi_ff[1]};
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'h07) begin
					rd_ff <= sh_ff[6];
					rd_addr <= {sh_ff[5:0], sdi_ff[1]};
				end
				if (cnt_ff == 5'h0F && !rd_ff) begin
					wr <= '{wr: 1'b1, addr: rd_addr, data: {sh_ff[6:0], sdi_ff[1]}};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data changes on falling sclk so the host samples it on the next rise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
			tx_ff <= 8'h00;
		end else if (!active) begin
			sdio_oe <= 1'b0;
		end else if (fall && rd_ff && cnt_ff >= 5'h08 && cnt_ff != 5'h10) begin
			sdio_oe <= 1'b1;
			if (cnt_ff == 5'h08) begin
				sdio_out <= rd_data[7];
				tx_ff <= {rd_data[6:0], 1'b0};
			end else begin
				sdio_out <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	a_oe_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!active |=> !sdio_oe) else $error("data pin driven outside a frame");

endmodule // ddtdc_spi_slave

// ---- ddtdc_top.sv ----
`timescale 1ns/10ps
// Function
// R01: Nine-bit delay tap register, codes 0 to 432, about 2 ps per code.
// R02: Tap drives the delay line whose output is the master digital clock.
// R03: Measure analog/digital phase and steer the tap onto the target phase.
// R04: Phase code 16 is 180 degrees; keep-out region sits around code 0.
// R05: Tap requests below 0 or above 432 drop lock or restart search.
// R06: Five-bit guard field; one guard step equals eight tap codes, both ends.
// R07: Host should program guard 11 steps, register value 0xCB.
// R08: Host configures this loop into tracking before any other controller.
// R09: First host write turns on the phase detector with boost.
// R10: Host then enables duty correction and picks negative slope.
// R11: Host then sets search/track, target phase and start tap 216.
// R12: Writing run bit starts the state machine; writing it again restarts search.
// R13: Search alternates around start tap until exact phase, then checks slope.
// R14: Guard hit switches to one direction; second hit resumes alternating.
// R15: Reaching delay line endpoints fails search; retry bit picks retry or stop.
// R16: Host waits typical lock time then polls the locked bit.
// R17: After phase and slope match, track drift with small tap steps.
// R18: Locked clears beyond four steps, lost sets if held; within three relocks.
// R19: After lost lock, keep tracking or restart search per relock bit.
// R20: Readback bit exposes the live tap and target phase in their registers.
// R21: Host picks target phase and slope per clock rate.
// R22: Below 1.6 GSPS host may rotate the quarter divider phase.
// R23: Output driver register bit 5 powers down the output data clock.
// R24: Lock and lost interrupt flags set only on false-to-true transitions.
// R25: Host may enable lock interrupt before start and wait for it.
module ddtdc_top import ddtdc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial configuration port
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_sdio_in,
	output logic spi_sdio_out,
	output logic spi_sdio_oe,
	// Analog phase detector
	input wire logic [4:0] phase_meas_async,
	// Delay line and clock path control
	output logic [8:0] dll_delay_tap,
	output logic [7:0] phase_detector_ctrl,
	output logic [7:0] duty_slope_ctrl,
	output logic output_data_clock_pd,
	// Status
	output logic dll_locked_flag,
	output logic dll_lost_flag,
	output logic dll_tracking,
	output logic dll_irq
);

	ddtdc_wr_s wr;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic [4:0] meas;
	logic sample;
	logic [7:0] out_drv_ff, irq_en_ff, pd_ff, duty_ff, gain_ff, phase_reg_ff, tap_reg_ff, guard_ff;
	logic locked_ff, lost_ff, locked_d_ff, lost_d_ff, lck_irq_ff, lst_irq_ff, irq_ff;
	ddtdc_state_e st_ff;
	ddtdc_smode_e mode_ff, adv_mode;
	logic [8:0] tap_ff, tap_d_ff, hit_tap_ff, up_ff, dn_ff, adv_up, adv_dn, adv_tap, cur_tap;
	logic guard_off_ff, adv_goff, adv_fail;
	logic [10:0] cand, lo, hi, req;
	logic [4:0] target, abs_d, pdiff;
	logic above, run_wr, slope_ok, probe_dn, range_flt, lose, readback;

	function automatic logic [4:0] mag5(input logic [4:0] d);
		mag5 = d[4] ? (~d + 5'h01) : d;
	endfunction

	function automatic logic [10:0] ext11(input logic [8:0] v);
		ext11 = {2'b00, v};
	endfunction

	ddtdc_spi_slave ddtdc_spi_slave_i (
		.clk(clk),
		.rst_b(rst_b),
		.sclk_pin(spi_sclk),
		.cs_b_pin(spi_cs_b),
		.sdio_in_pin(spi_sdio_in),
		.sdio_out(spi_sdio_out),
		.sdio_oe(spi_sdio_oe),
		.wr(wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	ddtdc_phase_sync #(.WIDTH(5), .SETTLE(SETTLE_CYC)) ddtdc_phase_sync_i (
		.clk(clk),
		.rst_b(rst_b),
		.phase_async(phase_meas_async),
		.retune(tap_ff != tap_d_ff),
		.phase(meas),
		.sample(sample)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_drv_ff <= RST_REG;
			irq_en_ff <= RST_REG;
			pd_ff <= RST_REG;
			duty_ff <= RST_REG;
			gain_ff <= RST_REG;
			phase_reg_ff <= RST_REG;
			tap_reg_ff <= RST_TAP_REG;
			guard_ff <= RST_REG;
		end else if (wr.wr) begin
			unique case (wr.addr)
				ADR_OUT_DRV: out_drv_ff <= wr.data;
				ADR_IRQ_EN: irq_en_ff <= wr.data;
				ADR_PD: pd_ff <= wr.data;
				ADR_DUTY: duty_ff <= wr.data;
				ADR_GAIN: gain_ff <= wr.data;
				ADR_PHASE: phase_reg_ff <= wr.data;
				ADR_TAP: tap_reg_ff <= wr.data;
				ADR_GUARD: guard_ff <= wr.data; // R06
				default: ;
			endcase
		end
	end

	assign readback = gain_ff[READBACK_BIT];

	// Readback bit swaps stored values for what the loop is really using
	always_comb begin
		unique case (rd_addr)
			ADR_OUT_DRV: rd_data = out_drv_ff;
			ADR_IRQ_EN: rd_data = irq_en_ff;
			ADR_IRQ_FLG: rd_data = {4'h0, lst_irq_ff, lck_irq_ff, 2'h0};
			ADR_PD: rd_data = pd_ff;
			ADR_DUTY: rd_data = duty_ff;
			ADR_GAIN: rd_data = gain_ff;
			ADR_PHASE: rd_data = readback ? {tap_ff[0], phase_reg_ff[6:0]} : phase_reg_ff; // R20
			ADR_TAP: rd_data = readback ? tap_ff[8:1] : tap_reg_ff; // R20
			ADR_GUARD: rd_data = guard_ff;
			ADR_STAT: rd_data = {6'h00, lost_ff, locked_ff};
			default: rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase arithmetic; 5-bit wrap gives 16 codes per half turn
	assign target = phase_reg_ff[4:0];
	assign pdiff = meas - target; // R04
	assign abs_d = mag5(pdiff);
	assign above = !pdiff[4] && pdiff != 5'h00;
	assign run_wr = wr.wr && wr.addr == ADR_GAIN; // R12
	assign probe_dn = hit_tap_ff == TAP_MAX;
	assign slope_ok = meas != target && ((above ^ probe_dn) == duty_ff[SLOPE_POS_BIT]); // R13
	assign lo = ext11({4'h0, guard_ff[4:0]}) << GUARD_SHIFT; // R06
	assign hi = ext11(TAP_MAX) - lo;
	assign cur_tap = (st_ff == ST_SLOPE) ? hit_tap_ff : tap_ff;

	// Tracking request: step against the phase error by one code plus the gain field
	assign req = (above ^ duty_ff[SLOPE_POS_BIT])
		? ext11(tap_ff) + ext11({7'h00, gain_ff[GAIN_LSB+1:GAIN_LSB]}) + 11'h001
		: ext11(tap_ff) - ext11({7'h00, gain_ff[GAIN_LSB+1:GAIN_LSB]}) - 11'h001;
	assign range_flt = pdiff != 5'h00 && (req[10] || req > ext11(TAP_MAX)); // R05
	assign lose = range_flt || abs_d > LOCK_DROP_STEPS;

	////////////////////////////////////////////////////////////////////////////////
	// Next search candidate, guard handling and endpoint failure
	always_comb begin
		adv_tap = cur_tap;
		adv_up = up_ff;
		adv_dn = dn_ff;
		adv_mode = mode_ff;
		adv_goff = guard_off_ff;
		adv_fail = 1'b0;
		if (mode_ff == SM_DN || (mode_ff == SM_ALT && up_ff > dn_ff)) begin
			cand = ext11(tap_reg_ff[7:0] * 9'h002 + {8'h00, phase_reg_ff[TAP_LSB_BIT]})
				- ext11(dn_ff) - 11'h001;
		end else begin
			cand = ext11(tap_reg_ff[7:0] * 9'h002 + {8'h00, phase_reg_ff[TAP_LSB_BIT]})
				+ ext11(up_ff) + 11'h001;
		end
		if (!guard_off_ff && (cand[10] || cand < lo || cand > hi)) begin
			if (mode_ff == SM_ALT) begin // R14
				adv_mode = (cand[10] || cand < lo) ? SM_UP : SM_DN;
			end else begin // R14
				adv_mode = SM_ALT;
				adv_goff = 1'b1;
			end
		end else if (cand[10] || cand > ext11(TAP_MAX)) begin
			adv_fail = 1'b1; // R15
		end else begin
			adv_tap = cand[8:0]; // R13
			if (cand > ext11(cur_tap) || (mode_ff != SM_DN && cand == ext11(cur_tap))) begin
				adv_up = up_ff + 9'h001;
			end else begin
				adv_dn = dn_ff + 9'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Controller state machine
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= ST_IDLE;
			tap_ff <= {RST_TAP_REG, 1'b0};
			tap_d_ff <= {RST_TAP_REG, 1'b0};
			hit_tap_ff <= 9'h000;
			up_ff <= 9'h000;
			dn_ff <= 9'h000;
			mode_ff <= SM_ALT;
			guard_off_ff <= 1'b0;
		end else begin
			tap_d_ff <= tap_ff;
			if (run_wr || (sample && st_ff == ST_FAILED && guard_ff[RETRY_BIT])
					|| (sample && st_ff == ST_TRACK && lose && locked_ff
					&& guard_ff[RELOCK_RESTART_BIT])) begin // R12 R15 R19
				tap_ff <= {tap_reg_ff, phase_reg_ff[TAP_LSB_BIT]}; // R13
				up_ff <= 9'h000;
				dn_ff <= 9'h000;
				mode_ff <= SM_ALT;
				guard_off_ff <= 1'b0;
				if (run_wr && !wr.data[RUN_BIT]) begin
					st_ff <= ST_IDLE;
				end else if (run_wr && !phase_reg_ff[SEARCH_EN_BIT]) begin
					st_ff <= ST_TRACK;
				end else begin
					st_ff <= ST_SEARCH;
				end
			end else if (sample) begin
				unique case (st_ff)
					ST_IDLE: ;
					ST_FAILED: ;
					ST_SEARCH, ST_SLOPE: begin
						if (st_ff == ST_SEARCH && meas == target) begin // R13
							hit_tap_ff <= tap_ff;
							tap_ff <= (tap_ff == TAP_MAX) ? tap_ff - 9'h001 : tap_ff + 9'h001;
							st_ff <= ST_SLOPE;
						end else if (st_ff == ST_SLOPE && slope_ok) begin
							tap_ff <= hit_tap_ff;
							st_ff <= ST_TRACK; // R17
						end else begin
							tap_ff <= adv_tap;
							up_ff <= adv_up;
							dn_ff <= adv_dn;
							mode_ff <= adv_mode;
							guard_off_ff <= adv_goff;
							st_ff <= adv_fail ? ST_FAILED : ST_SEARCH; // R15
						end
					end
					ST_TRACK: begin
						if (pdiff != 5'h00 && !range_flt) begin
							tap_ff <= req[8:0]; // R17 R03
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lock status with hysteresis
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			locked_ff <= 1'b0;
			lost_ff <= 1'b0;
		end else if (run_wr) begin
			locked_ff <= 1'b0;
		end else if (sample && st_ff == ST_TRACK) begin
			if (lose) begin // R18 R05
				locked_ff <= 1'b0;
				lost_ff <= lost_ff | locked_ff;
			end else if (abs_d <= LOCK_GAIN_STEPS) begin // R18
				locked_ff <= 1'b1;
				lost_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge-set interrupt flags; disabling the enable clears the flag and blocks any new edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			locked_d_ff <= 1'b0;
			lost_d_ff <= 1'b0;
			lck_irq_ff <= 1'b0;
			lst_irq_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			locked_d_ff <= locked_ff;
			lost_d_ff <= lost_ff;
			if (irq_en_ff[IRQ_LCK_BIT] && locked_ff && !locked_d_ff) begin
				lck_irq_ff <= 1'b1; // R24
			end else if (!irq_en_ff[IRQ_LCK_BIT]) begin
				lck_irq_ff <= 1'b0;
			end
			if (irq_en_ff[IRQ_LST_BIT] && lost_ff && !lost_d_ff) begin
				lst_irq_ff <= 1'b1; // R24
			end else if (!irq_en_ff[IRQ_LST_BIT]) begin
				lst_irq_ff <= 1'b0;
			end
			irq_ff <= lck_irq_ff | lst_irq_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dll_delay_tap <= {RST_TAP_REG, 1'b0};
			phase_detector_ctrl <= RST_REG;
			duty_slope_ctrl <= RST_REG;
			output_data_clock_pd <= 1'b0;
			dll_locked_flag <= 1'b0;
			dll_lost_flag <= 1'b0;
			dll_tracking <= 1'b0;
		end else begin
			dll_delay_tap <= tap_ff; // R01 R02
			phase_detector_ctrl <= pd_ff;
			duty_slope_ctrl <= duty_ff;
			output_data_clock_pd <= out_drv_ff[DCO_PD_BIT]; // R23
			dll_locked_flag <= locked_ff;
			dll_lost_flag <= lost_ff;
			dll_tracking <= st_ff == ST_TRACK;
		end
	end
	assign dll_irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_start;
		run_wr && wr.data[RUN_BIT] && phase_reg_ff[SEARCH_EN_BIT];
	endsequence
	sequence s_track_sample;
		sample && st_ff == ST_TRACK && !run_wr;
	endsequence

	a_tap_bound: assert property (tap_ff <= TAP_MAX) // R01
		else $error("tap beyond delay line");
	a_search_start: assert property (s_start |=> st_ff == ST_SEARCH // R12
		&& tap_ff == {$past(tap_reg_ff), $past(phase_reg_ff[TAP_LSB_BIT])})
		else $error("search did not start at programmed tap");
	a_lock_drop: assert property (s_track_sample and (abs_d > LOCK_DROP_STEPS) // R18
		|=> !locked_ff) else $error("lock kept beyond four steps");
	a_lost_set: assert property (s_track_sample and (locked_ff && lose) // R18
		|=> lost_ff) else $error("lost not flagged after held lock");
	a_relock: assert property (s_track_sample and (!range_flt && abs_d <= LOCK_GAIN_STEPS) // R18
		|=> locked_ff && !lost_ff) else $error("relock within three steps failed");
	a_track_step: assert property (s_track_sample and (pdiff != 5'h00 && !lose) // R17
		|=> tap_ff != $past(tap_ff)) else $error("tracking did not adjust tap");
	a_fail_hold: assert property (st_ff == ST_FAILED && !guard_ff[RETRY_BIT] && !run_wr // R15
		|=> st_ff == ST_FAILED) else $error("failed search left without retry");
	a_readback: assert property (readback && rd_addr == ADR_TAP // R20
		|-> rd_data == tap_ff[8:1]) else $error("readback not live tap");
	a_irq_edge: assert property ($rose(lck_irq_ff) // R24
		|-> $past(locked_ff) && !$past(locked_ff, 2)) else $error("lock flag without edge");
	a_dco_pd: assert property (output_data_clock_pd == $past(out_drv_ff[DCO_PD_BIT]) // R23
		or $past(!rst_b)) else $error("output clock power-down not following register");

endmodule // ddtdc_top

// ---- ddtdc_host.sv ----
`timescale 1ns/10ps
module ddtdc_host import ddtdc_pkg::*; (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic spi_sclk,
	output logic spi_cs_b,
	output logic spi_sdio_in,
	input wire logic spi_sdio_out,
	input wire logic spi_sdio_oe
);
	logic d = 1'b0;
	logic drv = 1'b1;
	localparam logic [6:0] ADR_DIV_ROT = 7'h14;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_b = 1'b1;
	end

	// Released line shows the inverse of the last bit so a stale copy never reads back
	assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (drv ? d : ~d);

	////////////////////////////////////////
	// Half period of six clocks keeps clear of the three-clock pin synchroniser
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [15:0] f;
		f = {rd, a, wd};
		q = 8'h00;
		@(negedge clk) spi_cs_b <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(negedge clk) spi_sclk <= 1'b0;
			drv <= !(rd && i < 8);
			if (!(rd && i < 8)) d <= f[i];
			repeat (6) @(negedge clk);
			if (rd && i < 8) q = {q[6:0], spi_sdio_in};
			spi_sclk <= 1'b1;
			repeat (5) @(negedge clk);
		end
		@(negedge clk) spi_sclk <= 1'b0;
		drv <= 1'b1;
		repeat (5) @(negedge clk);
		spi_cs_b <= 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] q;
		xfer(1'b0, a, v, q);
	endtask

	// Divider rotation belongs to the receiver; this loop must not take the write
	task automatic rotate_quarter(input logic [1:0] step);
		wr(ADR_DIV_ROT, {step, 6'h00});
	endtask

	// This loop is set up first, before any other controller
	task automatic boot();
		wr(ADR_PD, 8'h30);
		wr(ADR_DUTY, 8'h80);
		wr(ADR_PHASE, 8'h46);
		wr(ADR_TAP, 8'h6C);
		wr(ADR_GUARD, 8'hCB);
		wr(ADR_IRQ_EN, 8'h04);
		wr(ADR_GAIN, 8'h03);
	endtask

	// Lock time is scaled down to the short settle counts of this build
	task automatic poll_lock(output logic ok);
		logic [7:0] q;
		ok = 1'b0;
		repeat (300) @(negedge clk);
		repeat (20) begin
			if (!ok) begin
				xfer(1'b1, ADR_STAT, 8'h00, q);
				ok = q[0];
			end
		end
	endtask
endmodule // ddtdc_host

// ---- ddtdc_top_tb.sv ----
`timescale 1ns/10ps
module ddtdc_top_tb import ddtdc_pkg::*;;
	logic clk, rst_b, sclk, cs_b, sdi, sdo, oe, pdo, lkd, lst, trk, irq, flat, ok;
	logic [8:0] tap, ofs, t0;
	logic [7:0] pdc, dsc, q;
	logic [4:0] phase;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;

	// Steep falling curve: each code appears once per 32 taps, target 6 sits at tap 219
	assign phase = flat ? 5'h14 : 5'(9'h0E1 + ofs - tap);

	ddtdc_top ddtdc_top_i (.clk(clk), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b),
		.spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(oe), .phase_meas_async(phase),
		.dll_delay_tap(tap), .phase_detector_ctrl(pdc), .duty_slope_ctrl(dsc),
		.output_data_clock_pd(pdo), .dll_locked_flag(lkd), .dll_lost_flag(lst),
		.dll_tracking(trk), .dll_irq(irq));
	ddtdc_host ddtdc_host_i (.clk(clk), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdio_in(sdi),
		.spi_sdio_out(sdo), .spi_sdio_oe(oe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic rd(input logic [6:0] a);
		ddtdc_host_i.xfer(1'b1, a, 8'h00, q);
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		check(16'(tap), 16'h00D8);
		check(16'({lkd, lst, irq, pdo}), 16'h0000);
		rd(ADR_TAP);
		check(16'(q), 16'h006C);
		rd(ADR_STAT);
		check(16'(q), 16'h0000);
		rd(7'h7F);
		check(16'(q), 16'h0000);
		ddtdc_host_i.rotate_quarter(2'h1);
		rd(7'h14);
		check(16'(q), 16'h0000);
	endtask

	task automatic t_boot();
		ddtdc_host_i.boot();
		check(16'({pdc, dsc}), 16'h3080);
		ddtdc_host_i.poll_lock(ok);
		check(16'(ok), 16'h0001);
		check(16'(tap), 16'h00DB);
		check(16'({trk, irq}), 16'h0003);
	endtask

	task automatic t_pd();
		ddtdc_host_i.wr(ADR_OUT_DRV, 8'h20);
		check(16'(pdo), 16'h0001);
		ddtdc_host_i.wr(ADR_OUT_DRV, 8'h00);
		check(16'(pdo), 16'h0000);
	endtask

	task automatic t_readback();
		ddtdc_host_i.wr(ADR_GAIN, 8'h0B);
		ddtdc_host_i.poll_lock(ok);
		rd(ADR_TAP);
		check(16'(q), 16'h006D);
		rd(ADR_PHASE);
		check(16'(q & 8'h9F), 16'h0086);
	endtask

	task automatic t_drift();
		ofs = 9'h003;
		for (int k = 0; k < 300 && tap < 9'h0DD; k++) @(negedge clk);
		check(16'({tap >= 9'h0DD, lkd}), 16'h0003);
	endtask

	task automatic t_lost();
		ofs = 9'h00D;
		for (int k = 0; k < 100 && !lst; k++) @(negedge clk);
		check(16'({lkd, lst, trk}), 16'h0003);
		for (int k = 0; k < 400 && !lkd; k++) @(negedge clk);
		check(16'({lkd, lst}), 16'h0002);
	endtask

	// Restart on lost lock: a large jump drops lock and the search finds tap 219 again
	task automatic t_restart();
		ddtdc_host_i.wr(ADR_GUARD, 8'hEB);
		ofs = 9'h000;
		for (int k = 0; k < 100 && trk; k++) @(negedge clk);
		check(16'({trk, lst}), 16'h0001);
		ddtdc_host_i.poll_lock(ok);
		check(16'({ok, tap}), 16'h02DB);
	endtask

	// Target never measured, so the search must run out to the line ends
	task automatic t_fail();
		flat = 1'b1;
		ddtdc_host_i.wr(ADR_GUARD, 8'h8B);
		ddtdc_host_i.wr(ADR_GAIN, 8'h03);
		repeat (6000) @(negedge clk);
		t0 = tap;
		repeat (100) @(negedge clk);
		check(16'({trk, lkd, tap == t0}), 16'h0001);
		ddtdc_host_i.wr(ADR_GUARD, 8'hCB);
		ddtdc_host_i.wr(ADR_GAIN, 8'h03);
		repeat (8000) @(negedge clk);
		t0 = tap;
		repeat (40) @(negedge clk);
		check(16'(tap != t0), 16'h0001);
	endtask

	initial begin
		rst_b = 1'b0;
		flat = 1'b0;
		ofs = 9'h000;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_boot();
		t_pd();
		t_readback();
		t_drift();
		t_lost();
		t_restart();
		t_fail();
		finish_test();
	end
endmodule // ddtdc_top_tb
